/* rth_pkg.sv */
// Shared constants for the return-to-home sequencer
package rth_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int SPEED_W = 20;
  localparam int ACC_W   = 20;
  localparam int POS_W   = 24;
  localparam int PHASE_W = 28;

  // ****************************************
  // Homing mode codes
  // ****************************************
  localparam logic [1:0] MODE_TWO_SENSOR   = 2'h0;
  localparam logic [1:0] MODE_THREE_SENSOR = 2'h1;
  localparam logic [1:0] MODE_PUSH         = 2'h2;

  // ****************************************
  // Values after reset
  // ****************************************
  localparam logic [1:0]         RST_MODE      = MODE_THREE_SENSOR;
  localparam logic [SPEED_W-1:0] RST_RUN_HZ    = 20'h0_03E8;
  localparam logic [ACC_W-1:0]   RST_ACCEL     = 20'h0_03E8;
  localparam logic [SPEED_W-1:0] RST_START_HZ  = 20'h0_01F4;
  localparam logic [POS_W-1:0]   RST_OFFSET    = 24'h00_0000;
  localparam logic               RST_START_DIR = 1'b1;
  localparam logic               RST_SLOT_EN   = 1'b0;
  localparam logic               RST_PHASE_EN  = 1'b0;

  // ****************************************
  // Motion figures
  // ****************************************
  localparam logic [SPEED_W-1:0] FINAL_CAP_HZ = 20'h0_01F4;
  localparam logic [POS_W-1:0]   ESCAPE_STEPS = 24'h00_00C8;

  // ****************************************
  // Timing
  // ****************************************
  localparam int                 CLK_PERIOD_NS = 5;
  localparam logic [PHASE_W-1:0] CLK_HZ        = 28'hBEB_C200;
  // One accel unit is 1 ns per Hz of speed change
  localparam logic [ACC_W:0]     RAMP_NS_PER_CYCLE = (ACC_W+1)'(CLK_PERIOD_NS);

endpackage

/* motion_if.sv */
// Carrier between the sequencer, the step generator and the position counter
`timescale 1ns/1ps
`default_nettype none
interface motion_if;
  import rth_pkg::*;
  logic               go;
  logic               dir;
  logic [SPEED_W-1:0] start_hz;
  logic [SPEED_W-1:0] target_hz;
  logic [ACC_W-1:0]   accel;
  logic               clear;
  logic               step;
  logic               step_dir;

  modport ctrl (output go, dir, start_hz, target_hz, accel, clear, input step, step_dir);
  modport gen  (input go, dir, start_hz, target_hz, accel, output step, step_dir);
  modport pos  (input step, step_dir, clear);
endinterface
`default_nettype wire

/* step_pulse_gen.sv */
// Step pulse generator with linear speed ramp
`timescale 1ns/1ps
`default_nettype none
module step_pulse_gen
  import rth_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst,
  motion_if.gen     m
);

  logic [SPEED_W-1:0] cur_r;
  logic [SPEED_W-1:0] cur_nxt;
  logic [ACC_W:0]     ramp_r;
  logic [ACC_W:0]     ramp_sum;
  logic [PHASE_W-1:0] acc_r;
  logic [PHASE_W-1:0] acc_sum;
  logic               ramp_tick;
  logic               fire;

  // ****************************************
  // Ramp and phase accumulator
  // ****************************************
  assign ramp_sum  = ramp_r + RAMP_NS_PER_CYCLE;
  assign ramp_tick = ramp_sum >= {1'b0, m.accel};
  assign acc_sum   = acc_r + PHASE_W'(cur_r);
  assign fire      = acc_sum >= CLK_HZ;

  always_comb
  begin
    cur_nxt = cur_r;
    if (cur_r == '0)
      cur_nxt = m.start_hz;
    else if (ramp_tick && cur_r < m.target_hz)
      cur_nxt = cur_r + 1'b1;
    else if (ramp_tick && cur_r > m.target_hz)
      cur_nxt = cur_r - 1'b1;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cur_r      <= '0;
      ramp_r     <= '0;
      acc_r      <= '0;
      m.step     <= 1'b0;
      m.step_dir <= 1'b0;
    end
    else if (!m.go)
    begin
      cur_r  <= '0;
      ramp_r <= '0;
      acc_r  <= '0;
      m.step <= 1'b0;
    end
    else
    begin
      cur_r      <= cur_nxt;
      ramp_r     <= ramp_tick ? ramp_sum - {1'b0, m.accel} : ramp_sum;
      acc_r      <= fire ? acc_sum - CLK_HZ : acc_sum;
      m.step     <= fire;
      m.step_dir <= m.dir;
    end
  end

endmodule
`default_nettype wire

/* command_position.sv */
// Command position counter
`timescale 1ns/1ps
`default_nettype none
module command_position
  import rth_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  motion_if.pos           m,
  output logic [POS_W-1:0] position
);

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      position <= '0;
    else if (m.clear)
      position <= '0;
    else if (m.step)
      position <= m.step_dir ? position + 1'b1 : position - 1'b1;
  end

endmodule
`default_nettype wire

/* return_to_home_sequencer.sv */
// Return-to-home sequencer top
`timescale 1ns/1ps
`default_nettype none
module return_to_home_sequencer
  import rth_pkg::*;
(
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic                        origin_request,
  input  wire logic [1:0]                  mode_sel,
  input  wire logic [rth_pkg::SPEED_W-1:0] seek_run_speed,
  input  wire logic [rth_pkg::ACC_W-1:0]   seek_accel,
  input  wire logic [rth_pkg::SPEED_W-1:0] seek_start_speed,
  input  wire logic [rth_pkg::POS_W-1:0]   home_offset,
  input  wire logic                        start_dir_pos,
  input  wire logic                        slot_detect_en,
  input  wire logic                        phase_detect_en,
  input  wire logic                        origin_sensor,
  input  wire logic                        negative_limit_sensor,
  input  wire logic                        positive_limit_sensor,
  input  wire logic                        push_contact,
  input  wire logic                        slot_sensor_input,
  input  wire logic                        phase_sync_pulse,
  output logic                             ready,
  output logic                             origin_found,
  output logic                             step_pulse,
  output logic                             step_dir,
  output logic [rth_pkg::POS_W-1:0]        command_pos
);

  // ****************************************
  // Declarations
  // ****************************************
  typedef enum logic [2:0] {
    S_IDLE, S_SEEK, S_LEAVE, S_ESCAPE, S_PAUSE, S_QUALIFY, S_OFFSET, S_DONE
  } seq_state_e;

  seq_state_e         state_r;
  logic [1:0]         mode_r;
  logic [SPEED_W-1:0] run_hz_r;
  logic [SPEED_W-1:0] start_hz_r;
  logic [ACC_W-1:0]   accel_r;
  logic [POS_W-1:0]   offset_r;
  logic               slot_en_r;
  logic               phase_en_r;
  logic               go_r;
  logic               dir_r;
  logic               clear_r;
  logic [SPEED_W-1:0] gen_start_r;
  logic [SPEED_W-1:0] gen_target_r;
  logic [POS_W-1:0]   count_r;
  logic               ready_r;
  logic               found_r;

  motion_if m ();

  // ****************************************
  // Decoding
  // ****************************************
  wire                three_mode   = mode_r == MODE_THREE_SENSOR;
  wire                push_mode    = mode_r == MODE_PUSH;
  wire [SPEED_W-1:0]  final_hz     = (start_hz_r <= FINAL_CAP_HZ) ? start_hz_r
                                                                  : FINAL_CAP_HZ;
  wire                ahead_limit  = dir_r ? positive_limit_sensor
                                           : negative_limit_sensor;
  wire                behind_limit = dir_r ? negative_limit_sensor
                                           : positive_limit_sensor;
  wire                qualify_en   = slot_en_r | phase_en_r;
  wire                ext_hit      = (slot_en_r & slot_sensor_input) |
                                     (phase_en_r & phase_sync_pulse);
  wire                end_hit      = push_mode ? push_contact : ahead_limit;
  wire                end_clear    = push_mode ? !push_contact : !behind_limit;
  wire                accept       = origin_request && ready_r && state_r == S_IDLE;
  wire                offset_neg   = offset_r[POS_W-1];
  wire [POS_W-1:0]    offset_mag   = offset_neg ? POS_W'(-offset_r) : offset_r;
  wire                last_step    = m.step && count_r == POS_W'(1);
  wire                qual_done    = ext_hit && (!three_mode || origin_sensor);

  // ****************************************
  // Configuration held for one homing run
  // ****************************************
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      mode_r     <= RST_MODE;
      run_hz_r   <= RST_RUN_HZ;
      accel_r    <= RST_ACCEL;
      start_hz_r <= RST_START_HZ;
      offset_r   <= RST_OFFSET;
      slot_en_r  <= RST_SLOT_EN;
      phase_en_r <= RST_PHASE_EN;
    end
    else if (accept)
    begin
      mode_r     <= mode_sel;
      run_hz_r   <= seek_run_speed;
      accel_r    <= seek_accel;
      start_hz_r <= seek_start_speed;
      offset_r   <= home_offset;
      slot_en_r  <= slot_detect_en;
      phase_en_r <= phase_detect_en;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_r      <= S_IDLE;
      go_r         <= 1'b0;
      dir_r        <= RST_START_DIR;
      clear_r      <= 1'b0;
      gen_start_r  <= RST_START_HZ;
      gen_target_r <= RST_START_HZ;
      count_r      <= '0;
      ready_r      <= 1'b1;
      found_r      <= 1'b0;
    end
    else
    begin
      clear_r <= 1'b0;
      case (state_r)
        S_IDLE:
        begin
          if (accept)
          begin
            ready_r      <= 1'b0;
            found_r      <= 1'b0;
            dir_r        <= start_dir_pos;
            go_r         <= 1'b1;
            gen_start_r  <= seek_start_speed;
            gen_target_r <= (mode_sel == MODE_THREE_SENSOR) ? seek_run_speed
                                                            : seek_start_speed;
            state_r      <= S_SEEK;
          end
        end
        S_SEEK:
        begin
          if (three_mode)
          begin
            if (origin_sensor)
            begin
              go_r    <= 1'b0;
              state_r <= qualify_en ? S_PAUSE : S_OFFSET;
            end
            else if (ahead_limit)
            begin
              go_r  <= 1'b0;
              dir_r <= !dir_r;
            end
            else
              go_r <= 1'b1;
          end
          else if (end_hit)
          begin
            go_r    <= 1'b0;
            dir_r   <= !dir_r;
            state_r <= S_LEAVE;
          end
        end
        S_LEAVE:
        begin
          go_r <= 1'b1;
          if (end_clear)
          begin
            count_r <= ESCAPE_STEPS;
            state_r <= S_ESCAPE;
          end
        end
        S_ESCAPE:
        begin
          if (m.step)
            count_r <= count_r - 1'b1;
          if (last_step)
          begin
            go_r    <= 1'b0;
            state_r <= qualify_en ? S_PAUSE : S_OFFSET;
          end
        end
        S_PAUSE:
        begin
          go_r         <= 1'b1;
          gen_start_r  <= final_hz;
          gen_target_r <= final_hz;
          state_r      <= S_QUALIFY;
        end
        S_QUALIFY:
        begin
          if (qual_done)
          begin
            go_r    <= 1'b0;
            state_r <= S_OFFSET;
          end
          else if (ahead_limit)
          begin
            go_r  <= 1'b0;
            dir_r <= !dir_r;
          end
          else
            go_r <= 1'b1;
        end
        S_OFFSET:
        begin
          if (go_r)
          begin
            if (m.step)
              count_r <= count_r - 1'b1;
            if (last_step)
            begin
              go_r    <= 1'b0;
              clear_r <= 1'b1;
              state_r <= S_DONE;
            end
          end
          else if (offset_r == '0)
          begin
            clear_r <= 1'b1;
            state_r <= S_DONE;
          end
          else
          begin
            count_r      <= offset_mag;
            dir_r        <= !offset_neg;
            gen_start_r  <= start_hz_r;
            gen_target_r <= run_hz_r;
            go_r         <= 1'b1;
          end
        end
        S_DONE:
        begin
          clear_r <= 1'b1;
          found_r <= 1'b1;
          ready_r <= 1'b1;
          state_r <= S_IDLE;
        end
        default:
        begin
          go_r    <= 1'b0;
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Motion blocks
  // ****************************************
  assign m.go        = go_r;
  assign m.dir       = dir_r;
  assign m.start_hz  = gen_start_r;
  assign m.target_hz = gen_target_r;
  assign m.accel     = accel_r;
  assign m.clear     = clear_r;

  step_pulse_gen u_gen (
    .mclk (mclk),
    .rst  (rst),
    .m    (m.gen)
  );

  command_position u_pos (
    .mclk     (mclk),
    .rst      (rst),
    .m        (m.pos),
    .position (command_pos)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign ready        = ready_r;
  assign origin_found = found_r;
  assign step_pulse   = m.step;
  assign step_dir     = m.step_dir;

endmodule
`default_nettype wire

/* return_to_home_monitor.sv */
// Concurrent checks on the return-to-home sequencer ports
`timescale 1ns/1ps
`default_nettype none
module return_to_home_monitor
  import rth_pkg::*;
(
  input wire logic                      mclk,
  input wire logic                      rst,
  input wire logic                      origin_request,
  input wire logic                      ready,
  input wire logic                      origin_found,
  input wire logic                      step_pulse,
  input wire logic                      step_dir,
  input wire logic                      positive_limit_sensor,
  input wire logic                      negative_limit_sensor,
  input wire logic [rth_pkg::POS_W-1:0] command_pos
);
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  AST_ACCEPT: assert property (ready && origin_request |=> !ready && !origin_found)
    else $error("request while ready not taken");
  AST_IDLE: assert property (ready |-> !step_pulse)
    else $error("step while idle");
  AST_DONE: assert property ($rose(ready) |-> $rose(origin_found))
    else $error("ready back without origin found");
  AST_HOLD: assert property (origin_found && !origin_request |=> origin_found)
    else $error("origin found dropped");
  AST_ZERO: assert property ($rose(origin_found) |-> ready && command_pos == 24'h00_0000)
    else $error("position not zero at completion");
  AST_BUSY: assert property (!ready |-> !origin_found)
    else $error("origin found during a run");
  AST_GAP: assert property (step_pulse |=> !step_pulse [*8])
    else $error("steps faster than the speed limit");
  AST_TRACK: assert property (step_pulse |=> $rose(origin_found) ||
    command_pos == $past(command_pos) + ($past(step_dir) ? 24'h00_0001 : 24'hFF_FFFF))
    else $error("position does not follow steps");
  AST_PLIM: assert property (positive_limit_sensor && !ready |-> !(step_pulse && step_dir))
    else $error("step into positive limit");
  AST_NLIM: assert property (negative_limit_sensor && !ready |-> !(step_pulse && !step_dir))
    else $error("step into negative limit");

  COV_ACCEPT: cover property (ready && origin_request);
  COV_FOUND: cover property ($rose(origin_found));
  COV_LIMIT: cover property (positive_limit_sensor && !ready);
endmodule
`default_nettype wire

/* sensor_partner.sv */
// Mechanism model: position from steps, sensors from position
`timescale 1ns/1ps
`default_nettype none
module sensor_partner #(
  parameter int ORG_LO = 230,
  parameter int ORG_HI = 232,
  parameter int LIM    = 250
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        step_pulse,
  input  wire logic        step_dir,
  input  wire logic        load,
  input  wire logic [23:0] load_pos,
  output logic             origin_sensor,
  output logic             negative_limit_sensor,
  output logic             positive_limit_sensor,
  output logic             push_contact,
  output logic             slot_sensor_input,
  output logic             phase_sync_pulse,
  output logic [23:0]      mech_pos
);
  int p;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      mech_pos <= 24'h00_0000;
    else if (load)
      mech_pos <= load_pos;
    else if (step_pulse)
      mech_pos <= step_dir ? mech_pos + 24'h00_0001 : mech_pos - 24'h00_0001;
  end

  assign p = int'($signed(mech_pos));
  assign origin_sensor = (p >= ORG_LO) && (p <= ORG_HI);
  assign positive_limit_sensor = p >= LIM;
  assign negative_limit_sensor = p <= -LIM;
  assign push_contact = (p >= LIM) || (p <= -LIM);
  assign slot_sensor_input = origin_sensor;
  assign phase_sync_pulse = origin_sensor;
endmodule
`default_nettype wire

/* return_to_home_sequencer_tb.sv */
// Self-checking testbench for the return-to-home sequencer
`timescale 1ns/1ps
`default_nettype none
bind return_to_home_sequencer return_to_home_monitor u_mon (.mclk, .rst, .origin_request,
  .ready, .origin_found, .step_pulse, .step_dir, .positive_limit_sensor,
  .negative_limit_sensor, .command_pos);
module return_to_home_sequencer_tb;
  import rth_pkg::*;
  localparam logic [SPEED_W-1:0] FAST_HZ = 20'hF_4240;
  logic             mclk     = 1'b0;
  logic             rst      = 1'b1;
  logic             req      = 1'b0;
  logic [1:0]       mode     = MODE_THREE_SENSOR;
  logic [POS_W-1:0] offset   = 24'h00_0000;
  logic             dir_pos  = 1'b1;
  logic             slot_en  = 1'b0;
  logic             phase_en = 1'b0;
  logic             load     = 1'b0;
  logic [POS_W-1:0] load_pos = 24'h00_0000;
  logic             org, nlim, plim, contact, slot, phase;
  logic             ready, found, step, sdir;
  logic [POS_W-1:0] cpos, ppos;
  int               num_errors = 0;
  int               samples_checked = 0;

  initial
  begin
    forever #2.5 mclk = ~mclk;
  end

  return_to_home_sequencer DUT (.mclk(mclk), .rst(rst), .origin_request(req),
    .mode_sel(mode), .seek_run_speed(FAST_HZ), .seek_accel(20'h0_0001),
    .seek_start_speed(FAST_HZ), .home_offset(offset), .start_dir_pos(dir_pos),
    .slot_detect_en(slot_en), .phase_detect_en(phase_en), .origin_sensor(org),
    .negative_limit_sensor(nlim), .positive_limit_sensor(plim), .push_contact(contact),
    .slot_sensor_input(slot), .phase_sync_pulse(phase), .ready(ready),
    .origin_found(found), .step_pulse(step), .step_dir(sdir), .command_pos(cpos));

  sensor_partner u_mech (.mclk(mclk), .rst(rst), .step_pulse(step), .step_dir(sdir),
    .load(load), .load_pos(load_pos), .origin_sensor(org), .negative_limit_sensor(nlim),
    .positive_limit_sensor(plim), .push_contact(contact), .slot_sensor_input(slot),
    .phase_sync_pulse(phase), .mech_pos(ppos));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic run_case(input logic [1:0] m, input logic d, input logic [POS_W-1:0] sp,
                          input logic [POS_W-1:0] off, input logic se, input logic pe,
                          input logic [POS_W-1:0] exp, input logic poke);
    int n;
    @(posedge mclk);
    mode <= m;
    dir_pos <= d;
    offset <= off;
    slot_en <= se;
    phase_en <= pe;
    load <= 1'b1;
    load_pos <= sp;
    @(posedge mclk);
    load <= 1'b0;
    for (n = 0; n < 100 && ready !== 1'b1; n++) @(posedge mclk);
    chk(ready, 1'b1);
    if (ready !== 1'b1)
      summarize();
    req <= 1'b1;
    @(posedge mclk);
    #1;
    chk(ready, 1'b0);
    chk(found, 1'b0);
    @(posedge mclk);
    req <= 1'b0;
    if (poke)
    begin
      repeat (300) @(posedge mclk);
      req <= 1'b1;
      repeat (3) @(posedge mclk);
      req <= 1'b0;
      #1;
      chk(ready, 1'b0);
    end
    for (n = 0; n < 50000 && found !== 1'b1; n++) @(posedge mclk);
    if (n == 50000)
    begin
      num_errors++;
      summarize();
    end
    #1;
    chk(ready, 1'b1);
    chk(cpos, 24'h00_0000);
    chk(ppos, exp);
    $display("Test done: mode %0d start %h end %h", m, sp, ppos);
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial
  begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    run_case(MODE_THREE_SENSOR, 1'b1, 24'h00_00E1, 24'h00_0000, 1'b0, 1'b0, 24'h00_00E6, 1'b1);
    run_case(MODE_THREE_SENSOR, 1'b1, 24'h00_00F0, 24'h00_0000, 1'b0, 1'b1, 24'h00_00E8, 1'b0);
    run_case(MODE_THREE_SENSOR, 1'b1, 24'h00_00E1, 24'hFF_FFFD, 1'b1, 1'b0, 24'h00_00E3, 1'b0);
    run_case(MODE_TWO_SENSOR, 1'b0, 24'hFF_FF10, 24'h00_0000, 1'b0, 1'b0, 24'hFF_FFCF, 1'b0);
    run_case(MODE_PUSH, 1'b1, 24'h00_00F0, 24'h00_0000, 1'b0, 1'b0, 24'h00_0031, 1'b0);
    summarize();
  end
endmodule
`default_nettype wire
